// ### design/data_access_pkg.sv
// Shared constants and types for the data-space byte/word access unit
package data_access_pkg;
  localparam int DATA_W = 16;                  // Data path width
  localparam int ADDR_W = 16;                  // Effective address width
  localparam int BYTE_W = 8;                   // One byte lane
  localparam int LANES = 2;                    // Byte lanes per word
  localparam int NUM_WREGS = 8;                // Memory-mapped working registers
  localparam int WREG_IDX_W = 3;               // Working register select width
  localparam int MEM_BYTES_DEF = 8192;         // Implemented data memory
  localparam int EA_PSV_BIT = 15;              // Upper-half marker bit
  localparam int DIRECT_FIELD_W = 13;          // Short direct address field
  localparam int SIGN_BIT = 7;                 // Sign bit of a byte value
  localparam int BLOCK_LSB = 5;                // 32-byte block granularity
  localparam int BLOCK_MSB = 10;               // Top bit of the block index
  localparam logic [15:0] SFR_LIMIT = 16'h07ff;      // Last control-register byte
  localparam logic [15:0] INC_BYTE = 16'h0001;       // Post-increment, byte
  localparam logic [15:0] INC_WORD = 16'h0002;       // Post-increment, word
  localparam logic [15:0] WREG_RESET = 16'h0000;     // Working register reset
  localparam logic [15:0] ZERO_WORD = 16'h0000;      // Unimplemented read value
  localparam logic [7:0] ZERO_BYTE = 8'h00;          // Cleared upper byte
  localparam logic [1:0] LANE_NONE = 2'h0;           // No lane strobed
  localparam logic [1:0] LANE_LO = 2'h1;             // Even byte lane
  localparam logic [1:0] LANE_HI = 2'h2;             // Odd byte lane
  localparam logic [1:0] LANE_BOTH = 2'h3;           // Whole word
  // Implemented 32-byte blocks of the control-register region, bit n = block n
  localparam logic [63:0] SFR_BLOCK_MAP_DEF = 64'h0c670000_03cf177f;
  // Working register byte offsets
  localparam logic [15:0] WREG_OFFSET [NUM_WREGS] = '{
    16'h0000, 16'h0002, 16'h0004, 16'h9000,
    16'h8000, 16'h000a, 16'h000c, 16'h3000};
  // Where an effective address lands
  typedef enum logic [1:0] {
    RGN_WREG = 2'b00,
    RGN_RAM = 2'b01,
    RGN_SFR = 2'b10,
    RGN_NONE = 2'b11
  } region_t;
  // Extend operations on a working register
  typedef enum logic [1:0] {
    EXT_NONE = 2'b00,
    EXT_SIGN = 2'b01,
    EXT_ZERO = 2'b10
  } ext_op_t;
endpackage

// ### design/data_access_unit.sv
// Data-space access unit: byte/word steering, lane strobes, alignment traps
`timescale 1ns/1ps
// Behaviour
// - Data space is words; addresses are bytes
// - Even address low byte, odd address high
// - Post-increment adds one per byte, two per word
// - Byte read selects by bit 0, low lane
// - Shared word decode, per-lane write strobes
// - Odd word access raises address-error trap
// - Misaligned read completes; misaligned write suppressed
// - Byte load touches only register low byte
// - Sign extend copies bit 7 upward
// - Zero extend clears register upper byte
// - Short direct field reaches first 8 KB
// - Full direct field reaches whole space
// - Control registers sit in 0000h-07FFh
// - Unimplemented control addresses read zero
// - Control region decoded in 32-byte blocks
// - Word-only instructions never decode byte size
// - Beyond implemented memory reads all zero, except at working register offsets
// - Upper half is not data memory
module data_access_unit
  import data_access_pkg::*;
#(
  parameter int MEM_BYTES = MEM_BYTES_DEF,
  parameter logic [63:0] SFR_BLOCK_MAP = SFR_BLOCK_MAP_DEF
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic rd_req_in,
  input wire logic [ADDR_W-1:0] rd_addr_in,
  input wire logic rd_direct13_in,
  input wire logic rd_byte_in,
  input wire logic wr_req_in,
  input wire logic [ADDR_W-1:0] wr_addr_in,
  input wire logic wr_direct13_in,
  input wire logic wr_byte_in,
  input wire logic [DATA_W-1:0] wr_data_in,
  input wire logic word_only_in,
  input wire logic [ADDR_W-1:0] ptr_in,
  input wire logic ptr_byte_in,
  input wire logic wreg_load_in,
  input wire logic [WREG_IDX_W-1:0] wreg_sel_in,
  input wire logic wreg_byte_in,
  input wire logic [DATA_W-1:0] wreg_data_in,
  input wire logic [1:0] ext_op_in,
  output logic [ADDR_W-1:0] ptr_next_out,
  output logic [DATA_W-1:0] rd_data_out,
  output logic rd_valid_out,
  output logic sfr_hit_out,
  output logic [LANES-1:0] wr_lane_en_out,
  output logic addr_error_out
);

  localparam int MEM_WORDS = MEM_BYTES / LANES; // Words of data memory
  localparam int MEM_AW = $clog2(MEM_WORDS);    // Word index width
  localparam logic [15:0] MEM_LAST = 16'(MEM_BYTES - 1);

  // Storage: two byte lanes per word share one index
  logic [LANES-1:0][BYTE_W-1:0] mem [MEM_WORDS];
  logic [DATA_W-1:0] wreg_reg [NUM_WREGS];      // Working registers
  logic [DATA_W-1:0] rd_data_reg;               // Registered read data
  logic rd_valid_reg;                           // Read answer strobe
  logic sfr_hit_reg;                            // Read in the previous cycle hit a live block

  // Decoded request terms
  logic [ADDR_W-1:0] rd_ea;                     // Read effective address
  logic [ADDR_W-1:0] wr_ea;                     // Write effective address
  logic rd_is_byte;                             // Read is byte sized
  logic wr_is_byte;                             // Write is byte sized
  logic rd_mis;                                 // Odd word read
  logic wr_mis;                                 // Odd word write
  region_t rd_rgn;                              // Read target region
  region_t wr_rgn;                              // Write target region
  logic [WREG_IDX_W:0] rd_wsel;                 // Hit flag and index, read
  logic [WREG_IDX_W:0] wr_wsel;                 // Hit flag and index, write
  logic [LANES-1:0] wr_lane_next;               // Gated lane strobes
  logic [DATA_W-1:0] wr_lane_data;              // Write data on its lanes
  logic [DATA_W-1:0] rd_word;                   // Whole fetched word
  logic [DATA_W-1:0] rd_data_next;              // Steered read data

  // Short direct field drops the top bits; full field passes unchanged
  function automatic logic [ADDR_W-1:0] form_ea(input logic [ADDR_W-1:0] a, input logic short_field);
    if (short_field) begin
      form_ea = {{(ADDR_W-DIRECT_FIELD_W){1'b0}}, a[DIRECT_FIELD_W-1:0]};
    end else begin
      form_ea = a;
    end
  endfunction

  // Word-aligned match against the working register offsets
  function automatic logic [WREG_IDX_W:0] wreg_hit(input logic [ADDR_W-1:0] ea);
    wreg_hit = '0;
    for (int i = 0; i < NUM_WREGS; i++) begin
      if ({ea[ADDR_W-1:1], 1'b0} == WREG_OFFSET[i]) begin
        wreg_hit = {1'b1, WREG_IDX_W'(i)};
      end
    end
  endfunction

  // Region decode; registers first so their offsets always win
  function automatic region_t region_of(input logic [ADDR_W-1:0] ea);
    logic [WREG_IDX_W:0] h;
    h = wreg_hit(ea);
    if (h[WREG_IDX_W]) begin
      region_of = RGN_WREG;
    end else if (ea[EA_PSV_BIT]) begin
      region_of = RGN_NONE;
    end else if (ea <= SFR_LIMIT) begin
      // Block granularity only; contents of live blocks live elsewhere
      region_of = SFR_BLOCK_MAP[ea[BLOCK_MSB:BLOCK_LSB]] ? RGN_SFR : RGN_NONE;
    end else if (ea <= MEM_LAST) begin
      region_of = RGN_RAM;
    end else begin
      region_of = RGN_NONE;
    end
  endfunction

  // Size, address and alignment decode for both generators
  always_comb begin
    rd_is_byte = rd_byte_in & ~word_only_in;
    wr_is_byte = wr_byte_in & ~word_only_in;
    rd_ea = form_ea(rd_addr_in, rd_direct13_in);
    wr_ea = form_ea(wr_addr_in, wr_direct13_in);
    rd_mis = rd_req_in & ~rd_is_byte & rd_ea[0];
    wr_mis = wr_req_in & ~wr_is_byte & wr_ea[0];
    rd_rgn = region_of(rd_ea);
    wr_rgn = region_of(wr_ea);
    rd_wsel = wreg_hit(rd_ea);
    wr_wsel = wreg_hit(wr_ea);
  end

  // Trap is a pure function of the request cycle, so it lasts one cycle
  assign addr_error_out = rd_mis | wr_mis;

  // Post-modify step scaled by operand size
  assign ptr_next_out = ptr_in + (ptr_byte_in ? INC_BYTE : INC_WORD);

  // Lane strobes; a misaligned write strobes nothing
  always_comb begin
    if (!wr_req_in || wr_mis) begin
      wr_lane_next = LANE_NONE;
    end else if (!wr_is_byte) begin
      wr_lane_next = LANE_BOTH;
    end else if (wr_ea[0]) begin
      wr_lane_next = LANE_HI;
    end else begin
      wr_lane_next = LANE_LO;
    end
    // A byte rides on both lanes; the strobe picks the live one
    wr_lane_data = wr_is_byte ? {2{wr_data_in[BYTE_W-1:0]}} : wr_data_in;
  end
  assign wr_lane_en_out = wr_lane_next;

  // Data memory write; no reset on the array to keep it a plain RAM
  always_ff @(posedge mclk_in) begin
    if (wr_rgn == RGN_RAM) begin
      for (int l = 0; l < LANES; l++) begin
        if (wr_lane_next[l]) begin
          mem[wr_ea[MEM_AW:1]][l] <= wr_lane_data[l*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // Working registers: mapped writes, then loads, then extend operations
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < NUM_WREGS; i++) begin
        wreg_reg[i] <= WREG_RESET;
      end
    end else begin
      if (wr_rgn == RGN_WREG) begin
        for (int l = 0; l < LANES; l++) begin
          if (wr_lane_next[l]) begin
            wreg_reg[wr_wsel[WREG_IDX_W-1:0]][l*BYTE_W +: BYTE_W] <= wr_lane_data[l*BYTE_W +: BYTE_W];
          end
        end
      end
      // A direct load wins over a mapped write to the same register
      if (wreg_load_in) begin
        if (wreg_byte_in) begin
          wreg_reg[wreg_sel_in][BYTE_W-1:0] <= wreg_data_in[BYTE_W-1:0];
        end else begin
          wreg_reg[wreg_sel_in] <= wreg_data_in;
        end
      end else if (ext_op_in == EXT_SIGN) begin
        wreg_reg[wreg_sel_in][DATA_W-1:BYTE_W] <= {BYTE_W{wreg_reg[wreg_sel_in][SIGN_BIT]}};
      end else if (ext_op_in == EXT_ZERO) begin
        wreg_reg[wreg_sel_in][DATA_W-1:BYTE_W] <= ZERO_BYTE;
      end
    end
  end

  // Fetch the whole containing word, then steer the chosen byte low
  always_comb begin
    if (rd_rgn == RGN_WREG) begin
      rd_word = wreg_reg[rd_wsel[WREG_IDX_W-1:0]];
    end else if (rd_rgn == RGN_RAM) begin
      rd_word = mem[rd_ea[MEM_AW:1]];
    end else begin
      rd_word = ZERO_WORD;
    end
    if (rd_is_byte) begin
      rd_data_next = {ZERO_BYTE, rd_ea[0] ? rd_word[DATA_W-1:BYTE_W] : rd_word[BYTE_W-1:0]};
    end else begin
      // A misaligned read still completes with the aligned word
      rd_data_next = rd_word;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      rd_data_reg <= ZERO_WORD;
      rd_valid_reg <= 1'b0;
      sfr_hit_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_req_in;
      sfr_hit_reg <= rd_req_in && (rd_rgn == RGN_SFR);
      if (rd_req_in) begin
        rd_data_reg <= rd_data_next;
      end
    end
  end
  assign rd_data_out = rd_data_reg;
  assign rd_valid_out = rd_valid_reg;
  assign sfr_hit_out = sfr_hit_reg;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Byte write to a register, then a byte read of the same address
  sequence byte_wr_s;
    wr_req_in && wr_is_byte && !wr_mis && (wr_rgn == RGN_WREG) && !wreg_load_in && (ext_op_in == EXT_NONE);
  endsequence
  sequence byte_rd_same_s;
    rd_req_in && rd_is_byte && (rd_ea == $past(wr_ea)) && !wr_req_in;
  endsequence

  odd_word_trap_a: assert property ((rd_req_in && !rd_is_byte && rd_ea[0]) |-> addr_error_out)
    else $error("odd word read gave no trap");
  trap_gates_lanes_a: assert property (wr_mis |-> (addr_error_out && wr_lane_en_out == LANE_NONE))
    else $error("misaligned write still strobed lanes");
  trap_one_cycle_a: assert property ((addr_error_out && !rd_req_in ##1 !rd_req_in && !wr_req_in) |-> !addr_error_out)
    else $error("trap held without a request");
  byte_lane_pick_a: assert property ((wr_req_in && wr_is_byte) |-> (wr_lane_en_out == (wr_ea[0] ? LANE_HI : LANE_LO)))
    else $error("byte write strobed the wrong lane");
  word_only_lanes_a: assert property ((wr_req_in && word_only_in && !wr_ea[0]) |-> wr_lane_en_out == LANE_BOTH)
    else $error("word-only write was narrowed");
  ptr_step_a: assert property (ptr_next_out - ptr_in == (ptr_byte_in ? INC_BYTE : INC_WORD))
    else $error("post-increment step wrong");
  rd_answer_a: assert property (rd_req_in |=> rd_valid_out ##1 (rd_valid_out == $past(rd_req_in)))
    else $error("read answer not one cycle later");
  byte_rd_high_zero_a: assert property ((rd_req_in && rd_is_byte) |=> rd_data_out[DATA_W-1:BYTE_W] == ZERO_BYTE)
    else $error("byte read left upper lane set");
  upper_half_zero_a: assert property ((rd_req_in && rd_ea[EA_PSV_BIT] && rd_rgn != RGN_WREG) |=> rd_data_out == ZERO_WORD)
    else $error("upper half read not zero");
  sfr_hole_zero_a: assert property ((rd_req_in && rd_ea <= SFR_LIMIT && rd_rgn == RGN_NONE) |=> rd_data_out == ZERO_WORD)
    else $error("unimplemented control address not zero");
  byte_load_high_a: assert property ((wreg_load_in && wreg_byte_in && !wr_req_in) |=>
    wreg_reg[$past(wreg_sel_in)][15:8] == $past(wreg_reg[wreg_sel_in][15:8]))
    else $error("byte load disturbed upper byte");
  sign_ext_a: assert property ((!wreg_load_in && !wr_req_in && ext_op_in == EXT_SIGN) |=>
    wreg_reg[$past(wreg_sel_in)] == {{8{$past(wreg_reg[wreg_sel_in][7])}}, $past(wreg_reg[wreg_sel_in][7:0])})
    else $error("sign extend wrong");
  zero_ext_a: assert property ((!wreg_load_in && !wr_req_in && ext_op_in == EXT_ZERO) |=>
    wreg_reg[$past(wreg_sel_in)] == {8'h00, $past(wreg_reg[wreg_sel_in][7:0])})
    else $error("zero extend wrong");
  byte_roundtrip_a: assert property (byte_wr_s ##1 byte_rd_same_s |=> rd_data_out[7:0] == $past(wr_data_in[7:0], 2))
    else $error("byte written not read back");

endmodule

// ### test/core_model.sv
// Core-side model that drives requests into the data-space access unit
`timescale 1ns/1ps
module core_model
  import data_access_pkg::*;
(
  input wire logic mclk_in,
  output logic rd_req_out,
  output logic wr_req_out,
  output logic [ADDR_W-1:0] rd_addr_out,
  output logic [ADDR_W-1:0] wr_addr_out,
  output logic rd_d13_out,
  output logic wr_d13_out,
  output logic rd_byte_out,
  output logic wr_byte_out,
  output logic [DATA_W-1:0] wr_data_out,
  output logic word_only_out,
  output logic [ADDR_W-1:0] ptr_out,
  output logic ptr_byte_out,
  output logic load_out,
  output logic [WREG_IDX_W-1:0] sel_out,
  output logic load_byte_out,
  output logic [DATA_W-1:0] load_data_out,
  output logic [1:0] ext_out
);
  // Quiet lines at time zero
  initial begin
    {rd_req_out, wr_req_out, rd_d13_out, wr_d13_out, rd_byte_out, wr_byte_out, word_only_out} = 7'h00;
    {rd_addr_out, wr_addr_out, wr_data_out, ptr_out, load_data_out} = 80'h0;
    {ptr_byte_out, load_out, sel_out, load_byte_out, ext_out} = 8'h00;
  end
  // Size travels with address and data in the same cycle
  task automatic req(input logic rd, input logic [ADDR_W-1:0] a, input logic byt, input logic d13,
    input logic wo, input logic [DATA_W-1:0] d);
    @(posedge mclk_in);
    rd_req_out <= rd;
    wr_req_out <= !rd;
    {rd_addr_out, wr_addr_out, wr_data_out} <= {a, a, d};
    {rd_byte_out, wr_byte_out, rd_d13_out, wr_d13_out, word_only_out} <= {byt, byt, d13, d13, wo};
  endtask
  // Register load or extend on register 0, plus a pointer step
  task automatic misc(input logic ld, input logic byt, input logic [DATA_W-1:0] d, input logic [1:0] ext,
    input logic [ADDR_W-1:0] p, input logic pb);
    @(posedge mclk_in);
    {load_out, load_byte_out, load_data_out, ext_out} <= {ld, byt, d, ext};
    {ptr_out, ptr_byte_out} <= {p, pb};
  endtask
  // Released lines flip, so a stale value cannot pass for a fresh one
  task automatic idle();
    @(posedge mclk_in);
    {rd_req_out, wr_req_out, load_out, word_only_out, ext_out} <= 6'h00;
    {rd_addr_out, wr_addr_out, wr_data_out, load_data_out} <= ~{rd_addr_out, wr_addr_out, wr_data_out, load_data_out};
  endtask
endmodule

// ### test/data_access_unit_tb_top.sv
// Self-checking bench for the data-space access unit
`timescale 1ns/1ps
module data_access_unit_tb_top
  import data_access_pkg::*;
;
  // One case: f = {read, byte, direct13, word_only}, e = {lanes, trap, control hit}
  typedef struct packed {
    logic [3:0] f;
    logic [15:0] a;
    logic [15:0] d;
    logic [15:0] exp;
    logic [3:0] e;
  } row_t;
  logic mclk_in;
  logic rst_b_in;
  logic rd_req, wr_req, rd_d13, wr_d13, rd_byte, wr_byte, word_only, ptr_byte, load, load_byte;
  logic rd_valid, sfr_hit, addr_err;
  logic [15:0] rd_addr, wr_addr, wr_data, ptr, load_data, ptr_next, rd_data;
  logic [2:0] sel;
  logic [1:0] ext, lane_en;
  int errors = 0;
  int cmp_count = 0;
  // RAM at 0800 is not reset, so every read there follows a write
  row_t rows [23] = '{
    '{4'h0, 16'h0800, 16'h1234, 16'h0000, 4'hc}, '{4'h8, 16'h0800, 16'h0000, 16'h1234, 4'h0},
    '{4'hc, 16'h0801, 16'h0000, 16'h0012, 4'h0}, '{4'hc, 16'h0800, 16'h0000, 16'h0034, 4'h0},
    '{4'h4, 16'h0803, 16'hffab, 16'h0000, 4'h8}, '{4'h4, 16'h0802, 16'hffcd, 16'h0000, 4'h4},
    '{4'h8, 16'h0802, 16'h0000, 16'habcd, 4'h0}, '{4'h0, 16'h0805, 16'h5555, 16'h0000, 4'h2},
    '{4'h5, 16'h0803, 16'h9999, 16'h0000, 4'h2}, '{4'h8, 16'h0803, 16'h0000, 16'habcd, 4'h2},
    '{4'h8, 16'h0002, 16'h0000, 16'h0000, 4'h0}, '{4'h4, 16'h9001, 16'h0077, 16'h0000, 4'h8},
    '{4'h8, 16'h9000, 16'h0000, 16'h7700, 4'h0}, '{4'hc, 16'h9001, 16'h0000, 16'h0077, 4'h0},
    '{4'ha, 16'h2802, 16'h0000, 16'habcd, 4'h0}, '{4'h8, 16'h2802, 16'h0000, 16'h0000, 4'h0},
    '{4'h8, 16'ha000, 16'h0000, 16'h0000, 4'h0}, '{4'h8, 16'h0040, 16'h0000, 16'h0000, 4'h1},
    '{4'h8, 16'h0400, 16'h0000, 16'h0000, 4'h0}, '{4'h0, 16'h3000, 16'h4242, 16'h0000, 4'hc},
    '{4'h8, 16'h3000, 16'h0000, 16'h4242, 4'h0}, '{4'h5, 16'h0804, 16'h5a5a, 16'h0000, 4'hc},
    '{4'hd, 16'h0804, 16'h0000, 16'h5a5a, 4'h0}};
  core_model core (.mclk_in(mclk_in), .rd_req_out(rd_req), .wr_req_out(wr_req), .rd_addr_out(rd_addr),
    .wr_addr_out(wr_addr), .rd_d13_out(rd_d13), .wr_d13_out(wr_d13), .rd_byte_out(rd_byte),
    .wr_byte_out(wr_byte), .wr_data_out(wr_data), .word_only_out(word_only), .ptr_out(ptr),
    .ptr_byte_out(ptr_byte), .load_out(load), .sel_out(sel), .load_byte_out(load_byte),
    .load_data_out(load_data), .ext_out(ext));
  data_access_unit DUT (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
    .rd_direct13_in(rd_d13), .rd_byte_in(rd_byte), .wr_req_in(wr_req), .wr_addr_in(wr_addr),
    .wr_direct13_in(wr_d13), .wr_byte_in(wr_byte), .wr_data_in(wr_data), .word_only_in(word_only),
    .ptr_in(ptr), .ptr_byte_in(ptr_byte), .wreg_load_in(load), .wreg_sel_in(sel), .wreg_byte_in(load_byte),
    .wreg_data_in(load_data), .ext_op_in(ext), .ptr_next_out(ptr_next), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .sfr_hit_out(sfr_hit), .wr_lane_en_out(lane_en), .addr_error_out(addr_err));
  // 200 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic cmp_data(input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic [2:0] exp, input logic [2:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: flags %b, wanted %b", $time, got, exp);
    end
  endtask
  // Strobes and trap in the request cycle, registered answer one cycle later
  task automatic step(input row_t r);
    core.req(r.f[3], r.a, r.f[2], r.f[1], r.f[0], r.d);
    #1;
    cmp_flag(r.e[3:1], {lane_en, addr_err});
    core.idle();
    #1;
    cmp_flag({1'b0, r.f[3], r.e[0]}, {addr_err, rd_valid, sfr_hit});
    if (r.f[3]) cmp_data(r.exp, rd_data);
  endtask
  // Register 0 operation, then read it back through its mapped address
  task automatic wop(input logic ld, input logic byt, input logic [15:0] d, input logic [1:0] x,
    input logic [15:0] exp);
    core.misc(ld, byt, d, x, 16'h00ff, byt);
    #1;
    cmp_data(byt ? 16'h0100 : 16'h0101, ptr_next);
    core.idle();
    step('{4'h8, 16'h0000, 16'h0000, exp, 4'h0});
  endtask
  task automatic print_verdict();
    if (errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence: table first, then register operations and a second reset
  initial begin
    rst_b_in = 1'b0;
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    #1;
    cmp_data(16'h0000, rd_data);
    cmp_flag(3'h0, {rd_valid, sfr_hit, addr_err});
    foreach (rows[i]) step(rows[i]);
    // Byte write straight followed by a byte read of the same register address
    core.req(1'b0, 16'h0005, 1'b1, 1'b0, 1'b0, 16'h00c3);
    core.req(1'b1, 16'h0005, 1'b1, 1'b0, 1'b0, 16'h0000);
    core.idle();
    #1;
    cmp_data(16'h00c3, rd_data);
    wop(1'b1, 1'b0, 16'h1280, EXT_NONE, 16'h1280);
    wop(1'b1, 1'b1, 16'hff34, EXT_NONE, 16'h1234);
    wop(1'b1, 1'b1, 16'h0080, EXT_NONE, 16'h1280);
    wop(1'b0, 1'b0, 16'h0000, EXT_SIGN, 16'hff80);
    wop(1'b0, 1'b1, 16'h0000, EXT_ZERO, 16'h0080);
    wop(1'b0, 1'b0, 16'h0000, 2'h3, 16'h0080);
    // A reset in mid-run must clear the working registers again
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    @(posedge mclk_in);
    rst_b_in <= 1'b1;
    #1;
    // Read data held 0080 before this reset, so a zero here proves it was cleared
    cmp_data(16'h0000, rd_data);
    cmp_flag(3'h0, {rd_valid, sfr_hit, addr_err});
    step('{4'h8, 16'h9000, 16'h0000, 16'h0000, 4'h0});
    print_verdict();
  end
  // Watchdog, far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    #10000;
    errors++;
    print_verdict();
  end
endmodule
